/* File: logic/ccl_pkg.sv */
// Shared constants and carrier types for the comparator control logic.
// Assumes an 8-bit special-function register port driven by the CPU core.
package ccl_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RESPONSE_MODE  = 8'h9d;
    localparam logic [7:0] ADDR_INPUT_SELECT   = 8'h9f;
    localparam logic [7:0] ADDR_CONTROL_STATUS = 8'hf8;

    // ------------------------------------------------------------
    // Control and status field positions
    // ------------------------------------------------------------
    localparam int COMPARATOR_ON_BIT  = 7;
    localparam int COMPARE_RESULT_BIT = 6;
    localparam int RISE_SEEN_BIT      = 5;
    localparam int FALL_SEEN_BIT      = 4;
    localparam int PLUS_HYST_LSB      = 2;
    localparam int MINUS_HYST_LSB     = 0;

    // ------------------------------------------------------------
    // Mode and input select field positions
    // ------------------------------------------------------------
    localparam int RESPONSE_SPEED_LSB = 0;
    localparam int MINUS_INPUT_LSB    = 4;
    localparam int PLUS_INPUT_LSB     = 0;

    // ------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_WR_MASK = 8'hbf;
    localparam logic [7:0] MODE_WR_MASK    = 8'h03;
    localparam logic [7:0] SELECT_WR_MASK  = 8'h33;
    localparam logic [7:0] CONTROL_RESET   = 8'h00;
    localparam logic [7:0] MODE_RESET      = 8'h02;
    localparam logic [7:0] SELECT_RESET    = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
        logic       bit_wr;
        logic [2:0] bit_idx;
        logic       bit_val;
        logic       rd;
    } ccl_sfr_req_type;

    typedef struct packed {
        logic       power_on;
        logic [1:0] plus_hyst;
        logic [1:0] minus_hyst;
        logic [1:0] response_speed;
        logic [1:0] minus_input_sel;
        logic [1:0] plus_input_sel;
    } ccl_analog_ctrl_type;

endpackage : ccl_pkg

/* File: logic/ccl_sync.sv */
// Level synchroniser for the asynchronous comparator result.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/100ps
module ccl_sync #(
    parameter int STAGES = ccl_pkg::SYNC_STAGES
) (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_nrst,
    // Level in and out
    input  wire logic i_async,
    output logic      o_sync
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (STAGES < 2) begin : g_bad_stages
        $error("ccl_sync needs at least two stages");
    end

    logic [STAGES-1:0] stage;

    // Shift chain, only the last stage is read outside
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stage <= '0;
        end else begin
            stage <= {stage[STAGES-2:0], i_async};
        end
    end

    assign o_sync = stage[STAGES-1];

endmodule : ccl_sync

/* File: logic/ccl_top.sv */
// Comparator control logic: three special-function registers, result taps,
// edge flags and interrupt request levels around the analog comparator.
// Assumes the CPU core drives the register port synchronously to i_ref_clk
// and the analog core delivers its raw result asynchronously.
//
// Contract
// - Provide clocked and unclocked comparator result outputs.
// - Unclocked result follows comparator without any clock.
// - Disabled: pin outputs low, analog power off.
// - Control bit 7 enables comparator, resets 0.
// - Control bit 6 reads comparison result only.
// - Rising output edge sets control bit 5.
// - Falling output edge sets control bit 4.
// - Edge flags cleared only by software writing 0.
// - Interrupt request on rising and falling edges.
// - Control bits 3:2 pick positive hysteresis.
// - Control bits 1:0 pick negative hysteresis.
// - Mode bits 1:0 pick response speed.
// - Mode bits 7:2 read zero, writes ignored.
// - Select bits 5:4 pick negative input pin.
// - Select bits 1:0 pick positive input pin.
// - Select bits 7:6, 3:2 read zero.
// - Control register at 0xF8, bit-addressable.
`timescale 1ns/100ps
module ccl_top #(
    parameter int SYNC_STAGES = ccl_pkg::SYNC_STAGES
) (
    // Clock and reset
    input  wire logic                          i_ref_clk,
    input  wire logic                          i_nrst,
    // Register port from the CPU core
    input  wire ccl_pkg::ccl_sfr_req_type      i_sfr_req,
    output logic [7:0]                         o_sfr_rdata,
    output logic                               o_sfr_hit,
    // Analog comparator core
    input  wire logic                          i_raw_compare,
    output ccl_pkg::ccl_analog_ctrl_type       o_analog_ctrl,
    // Result taps towards the port pins
    output logic                               o_latched_compare_out,
    output logic                               o_raw_compare_out,
    // Interrupt request levels
    output logic                               o_rise_irq,
    output logic                               o_fall_irq,
    output logic                               o_compare_irq
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("ccl_top needs at least two synchroniser stages");
    end

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Byte or single-bit write applied to an old register value
    function automatic logic [7:0] apply_write(
        input logic [7:0]                old_val,
        input ccl_pkg::ccl_sfr_req_type  req,
        input logic [7:0]                mask
    );
        logic [7:0] merged;
        merged = old_val;
        if (req.wr) begin
            merged = req.wdata;
        end else if (req.bit_wr) begin
            merged[req.bit_idx] = req.bit_val;
        end
        apply_write = (merged & mask) | (old_val & ~mask);
    endfunction : apply_write

    // Address compare used for every register
    function automatic logic addr_is(
        input ccl_pkg::ccl_sfr_req_type req,
        input logic [7:0]               addr
    );
        addr_is = (req.addr == addr);
    endfunction : addr_is

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic       comparator_on_bit;
    logic       rise_seen_flag;
    logic       fall_seen_flag;
    logic [1:0] plus_hysteresis_sel;
    logic [1:0] minus_hysteresis_sel;
    logic [1:0] response_speed_sel;
    logic [1:0] minus_input_sel;
    logic [1:0] plus_input_sel;

    logic       compare_sync;
    logic       compare_prev;
    logic       compare_result_bit;
    logic       rise_event;
    logic       fall_event;

    logic       hit_control;
    logic       hit_mode;
    logic       hit_select;
    logic       any_write;
    logic       wr_control;
    logic       wr_mode;
    logic       wr_select;

    logic [7:0] control_value;
    logic [7:0] mode_value;
    logic [7:0] select_value;
    logic [7:0] next_control;
    logic [7:0] next_mode;
    logic [7:0] next_select;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------

    // Register hits and write strobes
    assign hit_control = addr_is(i_sfr_req, ccl_pkg::ADDR_CONTROL_STATUS);
    assign hit_mode    = addr_is(i_sfr_req, ccl_pkg::ADDR_RESPONSE_MODE);
    assign hit_select  = addr_is(i_sfr_req, ccl_pkg::ADDR_INPUT_SELECT);
    assign any_write   = i_sfr_req.wr | i_sfr_req.bit_wr;
    assign wr_control  = hit_control & any_write;
    assign wr_mode     = hit_mode & any_write;
    assign wr_select   = hit_select & any_write;

    // Hit indication for the register port
    assign o_sfr_hit = (hit_control | hit_mode | hit_select)
                     & (any_write | i_sfr_req.rd);

    // ------------------------------------------------------------
    // Comparator result path
    // ------------------------------------------------------------

    // Raw result into the clock domain
    ccl_sync #(
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_async   (i_raw_compare),
        .o_sync    (compare_sync)
    );

    // Status view of the synchronised result, zero while off
    assign compare_result_bit = compare_sync & comparator_on_bit;

    // Previous result for edge detection
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            compare_prev <= 1'b0;
        end else begin
            compare_prev <= compare_result_bit;
        end
    end

    // Edge events on the synchronised result
    assign rise_event = compare_result_bit & ~compare_prev;
    assign fall_event = ~compare_result_bit & compare_prev;

    // Clocked pin tap, low while disabled
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_latched_compare_out <= 1'b0;
        end else begin
            o_latched_compare_out <= compare_result_bit;
        end
    end

    // Unclocked pin tap, gated only by the enable
    assign o_raw_compare_out = i_raw_compare & comparator_on_bit;

    // ------------------------------------------------------------
    // Control and status register
    // ------------------------------------------------------------

    // Current byte view of the control register
    assign control_value = {comparator_on_bit,
                            compare_result_bit,
                            rise_seen_flag,
                            fall_seen_flag,
                            plus_hysteresis_sel,
                            minus_hysteresis_sel};

    // Byte or bit write merged into the writable fields
    always_comb begin
        next_control = control_value;
        if (wr_control) begin
            next_control = apply_write(control_value, i_sfr_req,
                                       ccl_pkg::CONTROL_WR_MASK);
        end
    end

    // Enable bit
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            comparator_on_bit <= ccl_pkg::CONTROL_RESET[ccl_pkg::COMPARATOR_ON_BIT];
        end else begin
            comparator_on_bit <= next_control[ccl_pkg::COMPARATOR_ON_BIT];
        end
    end

    // Rising edge flag, a new edge wins over a clear
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rise_seen_flag <= ccl_pkg::CONTROL_RESET[ccl_pkg::RISE_SEEN_BIT];
        end else begin
            rise_seen_flag <= next_control[ccl_pkg::RISE_SEEN_BIT]
                            | rise_event;
        end
    end

    // Falling edge flag, a new edge wins over a clear
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fall_seen_flag <= ccl_pkg::CONTROL_RESET[ccl_pkg::FALL_SEEN_BIT];
        end else begin
            fall_seen_flag <= next_control[ccl_pkg::FALL_SEEN_BIT]
                            | fall_event;
        end
    end

    // Hysteresis selects
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            plus_hysteresis_sel  <= ccl_pkg::CONTROL_RESET[ccl_pkg::PLUS_HYST_LSB +: 2];
            minus_hysteresis_sel <= ccl_pkg::CONTROL_RESET[ccl_pkg::MINUS_HYST_LSB +: 2];
        end else begin
            plus_hysteresis_sel  <= next_control[ccl_pkg::PLUS_HYST_LSB +: 2];
            minus_hysteresis_sel <= next_control[ccl_pkg::MINUS_HYST_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Response mode register
    // ------------------------------------------------------------

    // Byte view, upper bits fixed at zero
    assign mode_value = {6'h00, response_speed_sel};

    // Write merge
    always_comb begin
        next_mode = mode_value;
        if (wr_mode) begin
            next_mode = apply_write(mode_value, i_sfr_req,
                                    ccl_pkg::MODE_WR_MASK);
        end
    end

    // Speed select
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            response_speed_sel <= ccl_pkg::MODE_RESET[ccl_pkg::RESPONSE_SPEED_LSB +: 2];
        end else begin
            response_speed_sel <= next_mode[ccl_pkg::RESPONSE_SPEED_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Input select register
    // ------------------------------------------------------------

    // Byte view, unused bits fixed at zero
    assign select_value = {2'h0, minus_input_sel, 2'h0, plus_input_sel};

    // Write merge
    always_comb begin
        next_select = select_value;
        if (wr_select) begin
            next_select = apply_write(select_value, i_sfr_req,
                                      ccl_pkg::SELECT_WR_MASK);
        end
    end

    // Input pin selects
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            minus_input_sel <= ccl_pkg::SELECT_RESET[ccl_pkg::MINUS_INPUT_LSB +: 2];
            plus_input_sel  <= ccl_pkg::SELECT_RESET[ccl_pkg::PLUS_INPUT_LSB +: 2];
        end else begin
            minus_input_sel <= next_select[ccl_pkg::MINUS_INPUT_LSB +: 2];
            plus_input_sel  <= next_select[ccl_pkg::PLUS_INPUT_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    // Read mux, unmapped addresses return zero
    always_comb begin
        next_rdata = 8'h00;
        if (i_sfr_req.rd) begin
            if (hit_control) begin
                next_rdata = control_value;
            end else if (hit_mode) begin
                next_rdata = mode_value;
            end else if (hit_select) begin
                next_rdata = select_value;
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    // Registered read data
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sfr_rdata <= 8'h00;
        end else begin
            o_sfr_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Analog core controls
    // ------------------------------------------------------------

    // Settings towards the analog core
    always_comb begin
        o_analog_ctrl.power_on        = comparator_on_bit;
        o_analog_ctrl.plus_hyst       = plus_hysteresis_sel;
        o_analog_ctrl.minus_hyst      = minus_hysteresis_sel;
        o_analog_ctrl.response_speed  = response_speed_sel;
        o_analog_ctrl.minus_input_sel = minus_input_sel;
        o_analog_ctrl.plus_input_sel  = plus_input_sel;
    end

    // ------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------

    // Levels follow the sticky flags
    assign o_rise_irq    = rise_seen_flag;
    assign o_fall_irq    = fall_seen_flag;
    assign o_compare_irq = rise_seen_flag | fall_seen_flag;

endmodule : ccl_top

/* File: tb/ccl_checker.sv */
// Port checker for the comparator control logic.
// Assumes it is bound into ccl_top and sees only its ports.
`timescale 1ns/100ps
module ccl_checker #(
    parameter int SYNC_STAGES = ccl_pkg::SYNC_STAGES
) (
    // Clock and reset
    input wire logic                         i_ref_clk,
    input wire logic                         i_nrst,
    // Register port
    input wire ccl_pkg::ccl_sfr_req_type     i_sfr_req,
    input wire logic [7:0]                   o_sfr_rdata,
    input wire logic                         o_sfr_hit,
    // Comparator side and taps
    input wire logic                         i_raw_compare,
    input wire ccl_pkg::ccl_analog_ctrl_type o_analog_ctrl,
    input wire logic                         o_latched_compare_out,
    input wire logic                         o_raw_compare_out,
    input wire logic                         o_rise_irq,
    input wire logic                         o_fall_irq,
    input wire logic                         o_compare_irq
);
    // ------
    // Helpers
    // ------
    logic on;
    logic ctl_wr;
    logic rd_cs;
    logic rd_md;
    logic rd_mx;
    // Decoded request kinds
    assign on     = o_analog_ctrl.power_on;
    assign ctl_wr = (i_sfr_req.wr | i_sfr_req.bit_wr) && i_sfr_req.addr == 8'hf8;
    assign rd_cs  = i_sfr_req.rd && i_sfr_req.addr == 8'hf8;
    assign rd_md  = i_sfr_req.rd && i_sfr_req.addr == 8'h9d;
    assign rd_mx  = i_sfr_req.rd && i_sfr_req.addr == 8'h9f;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // ------
    // Assertions
    // ------
    raw_tap_a: assert property (o_raw_compare_out == (i_raw_compare & on))
        else $error("raw tap differs from gated comparator");
    off_pin_low_a: assert property (!on && !$past(on) |-> !o_latched_compare_out)
        else $error("latched tap high while disabled");
    latched_follow_a: assert property (($rose(i_raw_compare) && on && $past(on)) ##1 (i_raw_compare && on) [*3]
        |-> o_latched_compare_out && o_rise_irq) else $error("rise not seen on latched tap or flag");
    fall_seen_a: assert property (($fell(i_raw_compare) && on && $past(on)) ##1 (!i_raw_compare && on) [*3]
        |-> !o_latched_compare_out && o_fall_irq) else $error("fall not seen on latched tap or flag");
    rise_sticky_a: assert property (o_rise_irq && !ctl_wr |=> o_rise_irq)
        else $error("rise flag dropped without a write");
    fall_sticky_a: assert property (o_fall_irq && !ctl_wr |=> o_fall_irq)
        else $error("fall flag dropped without a write");
    irq_merge_a: assert property (o_compare_irq == (o_rise_irq | o_fall_irq))
        else $error("compare request not the merge of both flags");
    hit_decode_a: assert property (o_sfr_hit == ((i_sfr_req.wr | i_sfr_req.bit_wr | i_sfr_req.rd)
        && (i_sfr_req.addr inside {8'h9d, 8'h9f, 8'hf8}))) else $error("address hit decode wrong");
    rdata_idle_a: assert property (!$past(rd_cs | rd_md | rd_mx) |-> o_sfr_rdata == 8'h00)
        else $error("read data not zero without a mapped read");
    mode_unused_a: assert property ($past(rd_md) |-> o_sfr_rdata[7:2] == 6'h00)
        else $error("unused mode bits read nonzero");
    sel_unused_a: assert property ($past(rd_mx) |-> {o_sfr_rdata[7:6], o_sfr_rdata[3:2]} == 4'h0)
        else $error("unused select bits read nonzero");
    enable_read_a: assert property ($past(rd_cs) |-> o_sfr_rdata[7] == $past(on))
        else $error("enable bit readback differs from power control");
    status_read_a: assert property ($past(rd_cs) |-> o_sfr_rdata[6] == o_latched_compare_out)
        else $error("status bit differs from latched result");
endmodule : ccl_checker

bind ccl_top ccl_checker #(.SYNC_STAGES(SYNC_STAGES)) i_ccl_checker (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_sfr_req(i_sfr_req), .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit), .i_raw_compare(i_raw_compare), .o_analog_ctrl(o_analog_ctrl),
    .o_latched_compare_out(o_latched_compare_out), .o_raw_compare_out(o_raw_compare_out),
    .o_rise_irq(o_rise_irq), .o_fall_irq(o_fall_irq), .o_compare_irq(o_compare_irq)
);

/* File: tb/ccl_comparator_model.sv */
// Behavioural analog comparator core facing the control logic.
// Assumes the bench sets the wanted comparison result on i_level.
`timescale 1ns/100ps
module ccl_comparator_model #(
    parameter int STEP_NS = 20
) (
    // Control from the block
    input  wire ccl_pkg::ccl_analog_ctrl_type i_analog_ctrl,
    // Wanted result from the bench
    input  wire logic                         i_level,
    // Raw result to the block
    output logic                              o_raw_compare
);
    logic settled = 1'b0;
    logic noise;
    // Slower response codes answer later
    always @(i_level) settled <= #(STEP_NS * (1 + i_analog_ctrl.response_speed)) i_level;
    // Unpowered core output wanders, off the clock grid
    initial begin
        noise = 1'b0;
        #0.3;
        forever begin
            #37 noise = ~noise;
        end
    end
    // Powered core follows the level
    assign o_raw_compare = i_analog_ctrl.power_on ? settled : noise;
endmodule : ccl_comparator_model

/* File: tb/ccl_top_bench.sv */
// Self-checking bench for the comparator control logic.
// Assumes ccl_top with the comparator model on its analog side.
`timescale 1ns/100ps
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module ccl_top_bench;
    localparam int         DLY = 5;
    localparam logic [7:0] CS  = ccl_pkg::ADDR_CONTROL_STATUS;
    localparam logic [7:0] MD  = ccl_pkg::ADDR_RESPONSE_MODE;
    localparam logic [7:0] MX  = ccl_pkg::ADDR_INPUT_SELECT;
    logic                         i_ref_clk;
    logic                         i_nrst;
    ccl_pkg::ccl_sfr_req_type     sfr_req;
    logic [7:0]                   rdata;
    logic                         hit;
    logic                         raw;
    ccl_pkg::ccl_analog_ctrl_type actrl;
    logic                         latched;
    logic                         raw_out;
    logic                         rise_irq;
    logic                         fall_irq;
    logic                         cmp_irq;
    logic                         level;
    int                           num_errors;
    int                           checks_done;

    ccl_top i_ccl_top (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_sfr_req(sfr_req), .o_sfr_rdata(rdata),
        .o_sfr_hit(hit), .i_raw_compare(raw), .o_analog_ctrl(actrl), .o_latched_compare_out(latched),
        .o_raw_compare_out(raw_out), .o_rise_irq(rise_irq), .o_fall_irq(fall_irq), .o_compare_irq(cmp_irq)
    );
    ccl_comparator_model i_ccl_comparator_model (.i_analog_ctrl(actrl), .i_level(level), .o_raw_compare(raw));

    // Clock
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    // One register port request for one cycle, then idle
    task automatic sfr_op(input logic [7:0] a, input logic w, input logic [7:0] d, input logic bw,
                          input logic [2:0] bi, input logic bv, input logic r);
        @(posedge i_ref_clk);
        #DLY sfr_req = {a, w, d, bw, bi, bv, r};
        @(posedge i_ref_clk);
        #DLY sfr_req = '0;
    endtask : sfr_op
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        sfr_op(a, 1'b1, d, 1'b0, 3'h0, 1'b0, 1'b0);
    endtask : wr_byte
    task automatic wr_bit(input logic [2:0] i, input logic v);
        sfr_op(CS, 1'b0, 8'h00, 1'b1, i, v, 1'b0);
    endtask : wr_bit
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        sfr_op(a, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0, 1'b1);
        `CHECK(rdata, e);
    endtask : rd_chk
    // Wanted comparator level, off the sampling edge
    task automatic set_level(input logic v);
        @(posedge i_ref_clk);
        #DLY level = v;
    endtask : set_level
    // Bounded wait for the latched tap
    task automatic wait_latched(input logic v);
        int n;
        n = 0;
        while (latched !== v && n < 20) begin
            @(posedge i_ref_clk);
            #DLY n++;
        end
        `CHECK(latched, v);
    endtask : wait_latched
    // Reset and reset values
    task automatic do_reset(input int n);
        i_nrst = 1'b0;
        repeat (n) @(posedge i_ref_clk);
        #DLY i_nrst = 1'b1;
        rd_chk(CS, 8'h00);
        rd_chk(MD, 8'h02);
        rd_chk(MX, 8'h00);
        `CHECK(actrl, 11'h020);
        `CHECK(cmp_irq, 1'b0);
    endtask : do_reset
    task automatic finish_test;
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // Watchdog
    initial begin
        #100000;
        num_errors++;
        finish_test();
    end

    // ------
    // Stimulus
    // ------
    initial begin
        sfr_req = '0;
        level = 1'b0;
        num_errors = 0;
        checks_done = 0;
        do_reset(20);
        // Every code of each two-bit field, unused and read-only bits written high
        for (int c = 0; c < 4; c++) begin
            wr_byte(MD, {6'h3f, c[1:0]});
            rd_chk(MD, {6'h00, c[1:0]});
            `CHECK(actrl.response_speed, c[1:0]);
            wr_byte(MX, {2'b11, c[1:0], 2'b11, c[1:0]});
            rd_chk(MX, {2'b00, c[1:0], 2'b00, c[1:0]});
            `CHECK(actrl.minus_input_sel, c[1:0]);
            `CHECK(actrl.plus_input_sel, c[1:0]);
            wr_byte(CS, {4'h4, c[1:0], ~c[1:0]});
            rd_chk(CS, {4'h0, c[1:0], ~c[1:0]});
            `CHECK(actrl.plus_hyst, c[1:0]);
            `CHECK(actrl.minus_hyst, ~c[1:0]);
        end
        // Unmapped addresses
        wr_byte(8'hf9, 8'hff);
        rd_chk(8'h9e, 8'h00);
        rd_chk(CS, 8'h0c);
        // Disabled: pins low, no flags
        set_level(1'b1);
        repeat (10) @(posedge i_ref_clk);
        #DLY `CHECK(raw_out, 1'b0);
        `CHECK(latched, 1'b0);
        rd_chk(CS, 8'h0c);
        // Enable by bit write, clear spurious flags
        wr_bit(3'h7, 1'b1);
        wait_latched(1'b1);
        // Let spurious enable edges pass before the clears
        repeat (4) @(posedge i_ref_clk);
        wr_bit(3'h5, 1'b0);
        wr_bit(3'h4, 1'b0);
        rd_chk(CS, 8'hcc);
        `CHECK(raw_out, 1'b1);
        // Falling then rising edge, both flags kept
        set_level(1'b0);
        wait_latched(1'b0);
        rd_chk(CS, 8'h9c);
        `CHECK(cmp_irq, 1'b1);
        set_level(1'b1);
        wait_latched(1'b1);
        rd_chk(CS, 8'hfc);
        `CHECK(rise_irq, 1'b1);
        wr_bit(3'h4, 1'b0);
        rd_chk(CS, 8'hec);
        `CHECK(fall_irq, 1'b0);
        // Fast response code
        wr_byte(MD, 8'h00);
        wr_byte(CS, 8'h8c);
        set_level(1'b0);
        wait_latched(1'b0);
        rd_chk(CS, 8'h9c);
        // Disable with result high
        set_level(1'b1);
        wait_latched(1'b1);
        wr_bit(3'h7, 1'b0);
        `CHECK(raw_out, 1'b0);
        `CHECK(actrl.power_on, 1'b0);
        repeat (4) @(posedge i_ref_clk);
        #DLY rd_chk(CS, 8'h3c);
        // Reset in mid-run
        do_reset(2);
        finish_test();
    end
endmodule : ccl_top_bench
